// file: rtl/wcu_pkg.sv
// Package with constants and types for the watchpoint comparator unit.
package wcu_pkg;
  // Scan chain layout: data in bits 31..0, select in 36..32, direction in 37.
  localparam int CHAIN_W = 38;
  localparam int DATA_W = 32;
  localparam int SEL_W = 5;
  localparam int SEL_LSB = 32;
  localparam int RW_BIT = 37;
  localparam int NUM_UNITS = 2;
  // Select code: bits 4..3 pick the unit, bits 2..0 the register in it.
  localparam logic [1:0] SEL_UNIT0 = 2'h1;
  localparam logic [2:0] REG_ADDR_VALUE = 3'h0;
  localparam logic [2:0] REG_ADDR_MASK = 3'h1;
  localparam logic [2:0] REG_DATA_VALUE = 3'h2;
  localparam logic [2:0] REG_DATA_MASK = 3'h3;
  localparam logic [2:0] REG_CTRL_VALUE = 3'h4;
  localparam logic [2:0] REG_CTRL_MASK = 3'h5;
  // Control field positions.
  localparam int CTL_ENABLE = 8;
  localparam int CTL_RANGE = 7;
  localparam int CTL_CHAIN = 6;
  localparam int CTL_EXT = 5;
  localparam int CTL_PRIV = 4;
  localparam int CTL_ACC = 3;
  localparam int CTL_SIZE_LSB = 1;
  localparam int CTL_WRITE = 0;
  // Transfer size codes; code 2'h3 is reserved.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Lane masks for a 16-bit fetch, chosen by address bit 1.
  localparam logic [31:0] LANE_LOW = 32'h0000ffff;
  localparam logic [31:0] LANE_HIGH = 32'hffff0000;
  // Values after reset.
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [8:0] RST_CTRL_VALUE = 9'h000;
  localparam logic [7:0] RST_CTRL_MASK = 8'h00;
  localparam logic [37:0] RST_CHAIN = 38'h0;
  // Index of each pin in the synchroniser vector.
  localparam int SYN_TCK = 0;
  localparam int SYN_TDI = 1;
  localparam int SYN_SHIFT = 2;
  localparam int SYN_UPDATE = 3;
  localparam int SYN_TRST_N = 4;
  localparam int SYN_W = 5;
  localparam logic [4:0] RST_SYNC = 5'h10;

  // One bus cycle of the core as seen by the comparators.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic write;
    logic [1:0] size;
    logic priv;
    logic acc;
  } wcu_bus_s;
endpackage

// file: rtl/wcu_top.sv
// Two watchpoint comparator units with their serial register access chain.
//
// Contract
// - Two comparator units, each three value/mask pairs.
// - Access chain is 38 bits: data, select, direction.
// - Read uses direction 0; incoming data ignored.
// - Access happens only on update, not while shifting.
// - Set mask bit forces match; clear needs equality.
// - Control value bits 8..0; mask mirrors 7..0.
// - Enable bit unmaskable; gates the break signal.
// - Write field compared with core write indication.
// - Size field compared with transfer size code.
// - Access-type bit: 0 fetch, 1 data.
// - Privilege bit compared with not-translate signal.
// - Unit n compares external condition input n.
// - Unit 1 chain output feeds unit 0.
// - Chain register loads data match on address/control match.
// - Chain register cleared by control write, test reset.
// - Unit 1 range output drives unit 0 range.
// - 16-bit fetch compares only valid data half.
// - Disable bit suppresses match, break and range outputs, not the chain output.
`timescale 1ns/1ps
module wcu_top (
  input wire logic clk_i, // Core clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic tck_i, // Test clock pin, sampled by clk_i.
  input wire logic tdi_i, // Serial data in.
  input wire logic shift_dr_i, // Test port is in its data shift state.
  input wire logic update_dr_i, // Test port is in its data update state.
  input wire logic debug_test_reset_n_i, // Debug test reset, active low.
  input wire wcu_pkg::wcu_bus_s bus_i, // Core bus cycle, same clock domain.
  input wire logic [1:0] external_condition_i, // One condition line per unit.
  input wire logic comparator_disable_i, // Debug control comparator-disable bit.
  output logic tdo_o, // Serial data out.
  output logic internal_break_signal_o, // Enabled match of any unit.
  output logic [1:0] unit_match_o, // Enabled match per unit.
  output logic range_output_o, // Unit 1 range output.
  output logic chain_output_o // Unit 1 chain output.
);

  // Pin synchroniser: first stage is read only by the second stage.
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic tck_prev; // Delayed second stage, used to find the clock edges.
  logic upd_prev; // Delayed update level, used to find its rising edge.
  logic [4:0] pins;

  assign pins = {debug_test_reset_n_i, update_dr_i, shift_dr_i, tdi_i, tck_i};

  // Two flip-flops per pin; the test reset sits high at reset so it reads released.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= wcu_pkg::RST_SYNC;
      sync_b <= wcu_pkg::RST_SYNC;
      tck_prev <= 1'b0;
      upd_prev <= 1'b0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
      tck_prev <= sync_b[wcu_pkg::SYN_TCK];
      upd_prev <= sync_b[wcu_pkg::SYN_UPDATE];
    end
  end

  logic tck_rise; // One-cycle enable on a rising test clock edge.
  logic shift_en; // Shift one bit this cycle.
  logic upd_pulse; // Entry into the update state.
  logic trst_act; // Debug test reset asserted, synchronised.

  assign tck_rise = sync_b[wcu_pkg::SYN_TCK] & ~tck_prev;
  assign shift_en = tck_rise & sync_b[wcu_pkg::SYN_SHIFT];
  // The access happens once, on entry into update, never during shifting.
  assign upd_pulse = sync_b[wcu_pkg::SYN_UPDATE] & ~upd_prev;
  assign trst_act = ~sync_b[wcu_pkg::SYN_TRST_N];

  // The 38-bit access chain.
  logic [37:0] chain; // Shift register: direction, select, data.
  logic upd_write; // Update with direction set.
  logic [1:0] upd_unit; // Unit field of the select code.
  logic [2:0] upd_reg; // Register field of the select code.
  logic [31:0] rd_data; // Read data for the addressed register.

  assign upd_write = upd_pulse & chain[wcu_pkg::RW_BIT];
  assign upd_unit = chain[wcu_pkg::SEL_LSB + 3 +: 2];
  assign upd_reg = chain[wcu_pkg::SEL_LSB +: 3];

  // Comparator registers, one entry per unit.
  logic [31:0] addr_value [2];
  logic [31:0] addr_mask [2];
  logic [31:0] data_value [2];
  logic [31:0] data_mask [2];
  logic [8:0] ctrl_value [2];
  logic [7:0] ctrl_mask [2];
  logic [1:0] cv_write; // Control value write strobe per unit.
  logic [1:0] hit; // Full match per unit, before the enable bit.
  logic [1:0] ac_match; // Address and control match per unit.
  logic [1:0] d_match; // Data match per unit.
  logic [1:0] chain_q; // Chain register per unit.
  logic [1:0] range_in; // Range input per unit.
  logic [1:0] chain_in; // Chain input per unit.
  logic [7:0] ctl_in [2]; // Live control vector per unit.
  logic [31:0] rd_unit [2]; // Read data per unit.

  // Shift on test clock edges; on a read update the data field is replaced
  // by the register contents so the next scan carries them out.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chain <= wcu_pkg::RST_CHAIN;
    end else if (trst_act) begin
      chain <= wcu_pkg::RST_CHAIN;
    end else if (shift_en) begin
      chain <= {sync_b[wcu_pkg::SYN_TDI], chain[37:1]};
    end else if (upd_pulse && !chain[wcu_pkg::RW_BIT]) begin
      chain[31:0] <= rd_data;
    end
  end

  // Serial output follows the chain end; a register keeps it glitch free.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tdo_o <= 1'b0;
    end else begin
      tdo_o <= chain[0];
    end
  end

  // Read data picks the addressed unit; unmapped codes read as zero.
  always_comb begin
    rd_data = wcu_pkg::RST_WORD;
    if (upd_unit == wcu_pkg::SEL_UNIT0) begin
      rd_data = rd_unit[0];
    end else if (upd_unit == wcu_pkg::SEL_UNIT0 + 2'h1) begin
      rd_data = rd_unit[1];
    end
  end

  // Unit 1 has nothing to chain to; unit 0 takes unit 1 outputs.
  assign range_in[1] = 1'b0;
  assign chain_in[1] = 1'b0;
  assign range_in[0] = hit[1];
  assign chain_in[0] = chain_q[1];

  // One comparator unit per loop pass.
  for (genvar u = 0; u < wcu_pkg::NUM_UNITS; u++) begin : g_unit
    logic sel_me; // This unit is addressed by the select field.
    logic [31:0] lane; // Data bits that take part in the comparison.
    logic fetch16; // A 16-bit instruction fetch.
    logic a_ok;
    logic c_ok;

    assign sel_me = (upd_unit == 2'(u) + wcu_pkg::SEL_UNIT0);
    assign cv_write[u] = upd_write & sel_me & (upd_reg == wcu_pkg::REG_CTRL_VALUE);

    // Register writes; the incoming data field is ignored for reads.
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        addr_value[u] <= wcu_pkg::RST_WORD;
        addr_mask[u] <= wcu_pkg::RST_WORD;
        data_value[u] <= wcu_pkg::RST_WORD;
        data_mask[u] <= wcu_pkg::RST_WORD;
        ctrl_value[u] <= wcu_pkg::RST_CTRL_VALUE;
        ctrl_mask[u] <= wcu_pkg::RST_CTRL_MASK;
      end else if (upd_write && sel_me) begin
        unique case (upd_reg)
          wcu_pkg::REG_ADDR_VALUE: addr_value[u] <= chain[31:0];
          wcu_pkg::REG_ADDR_MASK: addr_mask[u] <= chain[31:0];
          wcu_pkg::REG_DATA_VALUE: data_value[u] <= chain[31:0];
          wcu_pkg::REG_DATA_MASK: data_mask[u] <= chain[31:0];
          wcu_pkg::REG_CTRL_VALUE: ctrl_value[u] <= chain[8:0];
          wcu_pkg::REG_CTRL_MASK: ctrl_mask[u] <= chain[7:0];
          default: ;
        endcase
      end
    end

    // Read back; narrow registers sit in the low bits with zeros above.
    always_comb begin
      rd_unit[u] = wcu_pkg::RST_WORD;
      unique case (upd_reg)
        wcu_pkg::REG_ADDR_VALUE: rd_unit[u] = addr_value[u];
        wcu_pkg::REG_ADDR_MASK: rd_unit[u] = addr_mask[u];
        wcu_pkg::REG_DATA_VALUE: rd_unit[u] = data_value[u];
        wcu_pkg::REG_DATA_MASK: rd_unit[u] = data_mask[u];
        wcu_pkg::REG_CTRL_VALUE: rd_unit[u] = {23'h000000, ctrl_value[u]};
        wcu_pkg::REG_CTRL_MASK: rd_unit[u] = {24'h000000, ctrl_mask[u]};
        default: rd_unit[u] = wcu_pkg::RST_WORD;
      endcase
    end

    // Live control vector in the same layout as the control registers.
    assign ctl_in[u] = {range_in[u], chain_in[u], external_condition_i[u],
                        bus_i.priv,
                        bus_i.acc,
                        bus_i.size,
                        bus_i.write};

    // Only the valid half of the bus counts on a 16-bit fetch.
    assign fetch16 = ~bus_i.acc & (bus_i.size == wcu_pkg::SIZE_HALF);
    assign lane = !fetch16 ? 32'hffffffff :
                  (bus_i.addr[1] ? wcu_pkg::LANE_HIGH : wcu_pkg::LANE_LOW);

    // A set mask bit always matches, so the masks act as XNOR masks.
    assign a_ok = &(~(bus_i.addr ^ addr_value[u]) | addr_mask[u]);
    assign d_match[u] = &(~(bus_i.data ^ data_value[u]) | data_mask[u] | ~lane);
    assign c_ok = &(~(ctl_in[u] ^ ctrl_value[u][7:0]) | ctrl_mask[u]);
    assign ac_match[u] = bus_i.valid & a_ok & c_ok;
    // All three fields must agree in the same cycle.
    assign hit[u] = ac_match[u] & d_match[u];

    // Chain register: written when address and control agree; cleared by a
    // control value write or test reset, which take priority.
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        chain_q[u] <= 1'b0;
      end else if (cv_write[u] || trst_act) begin
        chain_q[u] <= 1'b0;
      end else if (ac_match[u]) begin
        chain_q[u] <= d_match[u];
      end
    end
  end

  // Registered outputs; the disable bit silences the match, break and range outputs.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      unit_match_o <= 2'h0;
      internal_break_signal_o <= 1'b0;
      range_output_o <= 1'b0;
    end else begin
      unit_match_o <= comparator_disable_i ? 2'h0 :
                      (hit & {ctrl_value[1][wcu_pkg::CTL_ENABLE],
                              ctrl_value[0][wcu_pkg::CTL_ENABLE]});
      internal_break_signal_o <= ~comparator_disable_i &
                                 |(hit & {ctrl_value[1][wcu_pkg::CTL_ENABLE],
                                          ctrl_value[0][wcu_pkg::CTL_ENABLE]});
      range_output_o <= ~comparator_disable_i & hit[1];
    end
  end

  // The chain output is the chain register itself, already a flip-flop.
  assign chain_output_o = chain_q[1];

  // Registers move only on an update write.
  AST_UPDATE_ONLY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !upd_write |=> $stable(ctrl_value[0]) && $stable(addr_value[1]) && $stable(data_mask[0]))
    else $error("Comparator register changed without an update write.");
  // A read update never changes a register.
  AST_READ_NO_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (upd_pulse && !chain[wcu_pkg::RW_BIT]) |=> $stable(addr_value[0]) && $stable(ctrl_mask[1]))
    else $error("Read access altered a register.");
  // Break needs an enabled hit one cycle before.
  AST_BREAK_ENABLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    internal_break_signal_o |-> $past(hit[0] & ctrl_value[0][wcu_pkg::CTL_ENABLE]) ||
                                $past(hit[1] & ctrl_value[1][wcu_pkg::CTL_ENABLE]))
    else $error("Break raised without an enabled match.");
  // Disable bit suppresses outputs on the next cycle.
  AST_DISABLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    comparator_disable_i |=> !internal_break_signal_o && unit_match_o == 2'h0)
    else $error("Match output while comparators disabled.");
  // Control value write clears the chain register.
  AST_CHAIN_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cv_write[1] || trst_act) |=> chain_q[1] == 1'b0)
    else $error("Chain register not cleared.");
  // Chain register loads the data result under address/control match.
  AST_CHAIN_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ac_match[1] && !cv_write[1] && !trst_act) |=> chain_q[1] == $past(d_match[1]))
    else $error("Chain register did not load the data result.");
  // All masks set gives a match on any valid cycle.
  AST_MASK_ALL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (bus_i.valid && &addr_mask[0] && &data_mask[0] && &ctrl_mask[0]) |-> hit[0])
    else $error("Fully masked unit failed to match.");
  // Unit 0 range field tracks unit 1 match.
  AST_RANGE_LINK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (hit[0] && !ctrl_mask[0][wcu_pkg::CTL_RANGE]) |-> ctrl_value[0][wcu_pkg::CTL_RANGE] == hit[1])
    else $error("Unit 0 matched against the wrong range input.");
  // Unit 0 chain field tracks unit 1 chain register.
  AST_CHAIN_LINK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (hit[0] && !ctrl_mask[0][wcu_pkg::CTL_CHAIN]) |->
      ctrl_value[0][wcu_pkg::CTL_CHAIN] == chain_q[1])
    else $error("Unit 0 matched against the wrong chain input.");
  // Unit 1 external field tracks its own condition line.
  AST_EXT_LINE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (hit[1] && !ctrl_mask[1][wcu_pkg::CTL_EXT]) |->
      ctrl_value[1][wcu_pkg::CTL_EXT] == external_condition_i[1])
    else $error("Unit 1 matched against the wrong condition line.");
  // On a low-half 16-bit fetch the upper data half must not spoil the compare.
  AST_LANE16: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (bus_i.valid && !bus_i.acc && bus_i.size == wcu_pkg::SIZE_HALF && !bus_i.addr[1]) |->
      d_match[1] == &(~(bus_i.data[15:0] ^ data_value[1][15:0]) | data_mask[1][15:0]))
    else $error("Unused data half took part in a 16-bit fetch compare.");
  // The serial output shows the chain end one cycle later.
  AST_TDO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> tdo_o == $past(chain[0]))
    else $error("Serial output lost the chain end.");

  COV_BREAK_U0: cover property (@(posedge clk_i) disable iff (!nrst_i) unit_match_o[0]);
  COV_CHAINED: cover property (@(posedge clk_i) disable iff (!nrst_i) chain_q[1] ##1 hit[0]);
  COV_WRITE: cover property (@(posedge clk_i) disable iff (!nrst_i) cv_write[0]);
  COV_READ: cover property (@(posedge clk_i) disable iff (!nrst_i)
    upd_pulse && !chain[wcu_pkg::RW_BIT]);
  COV_FETCH16: cover property (@(posedge clk_i) disable iff (!nrst_i)
    hit[1] && !bus_i.acc && bus_i.size == wcu_pkg::SIZE_HALF);
endmodule

// file: test/wcu_jtag_host.sv
// Debugger host model that drives the serial register access chain.
`timescale 1ns/1ps
module wcu_jtag_host (
  input wire logic clk_i, // Core clock, used only as a time base.
  input wire logic tdo_i, // Serial data from the device.
  output logic tck_o, // Test clock, still between frames.
  output logic tdi_o, // Serial data to the device.
  output logic shift_dr_o, // Shift state flag.
  output logic update_dr_o // Update state flag.
);
  // The port starts idle with the test clock low.
  initial begin
    tck_o = 1'b0;
    tdi_o = 1'b0;
    shift_dr_o = 1'b0;
    update_dr_o = 1'b0;
  end

  // Shifts one frame LSB first and collects the outgoing bits, then pulses update.
  // The test clock runs at 8 core cycles, so flags stay stable around its edges.
  task automatic scan(input logic [37:0] v, output logic [37:0] got);
    @(negedge clk_i);
    shift_dr_o = 1'b1;
    for (int i = 0; i < 38; i++) begin
      tdi_o = v[i];
      repeat (4) @(negedge clk_i);
      got[i] = tdo_i;
      tck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      tck_o = 1'b0;
    end
    shift_dr_o = 1'b0;
    // A released line must not keep its last value, so it flips.
    tdi_o = ~tdi_o;
    repeat (4) @(negedge clk_i);
    update_dr_o = 1'b1;
    repeat (6) @(negedge clk_i);
    update_dr_o = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  // A write carries the value, the select code and the direction bit set.
  task automatic wr(input logic [4:0] sel, input logic [31:0] d);
    logic [37:0] g;
    scan({1'b1, sel, d}, g);
  endtask

  // A read sends junk data with direction clear; a second frame brings it out.
  task automatic rd(input logic [4:0] sel, input logic [31:0] junk, output logic [31:0] q);
    logic [37:0] g;
    scan({1'b0, sel, junk}, g);
    scan({1'b0, 5'h00, ~junk}, g);
    q = g[31:0];
  endtask
endmodule

// file: test/test_watchpoint_comparator_unit.sv
// Self-checking testbench for the watchpoint comparator unit.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_watchpoint_comparator_unit;
  logic clk_i = 1'b0; // Core clock, 50 ns period.
  logic nrst_i = 1'b0; // Reset, held for 10 cycles.
  logic tck_i, tdi_i, shift_dr_i, update_dr_i; // Driven by the host model.
  logic debug_test_reset_n_i = 1'b0; // Debug test reset.
  wcu_pkg::wcu_bus_s bus_i = '0; // Core bus cycle.
  logic [1:0] external_condition_i = 2'h0; // Condition lines.
  logic comparator_disable_i = 1'b1; // Kept high while programming.
  logic tdo_o, internal_break_signal_o, range_output_o, chain_output_o; // Outputs.
  logic [1:0] unit_match_o; // Per-unit matches.
  int checked = 0; // Comparisons made.
  int miscompares = 0; // Comparisons failed.
  logic [31:0] seed = 32'h42d6; // Random state, fixed start.
  logic [31:0] av[2], am[2], dv[2], dm[2]; // Programmed address and data pairs.
  logic [8:0] cv[2]; // Programmed control values.
  logic [7:0] cm[2]; // Programmed control masks.
  logic [1:0] um = 2'h0; // Expected per-unit matches for the last bus cycle.
  logic ib = 1'b0; // Expected break for the last bus cycle.
  logic rg = 1'b0; // Expected range output for the last bus cycle.
  logic ch = 1'b0; // Expected unit 1 chain register.

  // Clock generator.
  always #25 clk_i = ~clk_i;

  wcu_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck_i), .tdi_i(tdi_i),
    .shift_dr_i(shift_dr_i), .update_dr_i(update_dr_i),
    .debug_test_reset_n_i(debug_test_reset_n_i), .bus_i(bus_i),
    .external_condition_i(external_condition_i), .comparator_disable_i(comparator_disable_i),
    .tdo_o(tdo_o), .internal_break_signal_o(internal_break_signal_o),
    .unit_match_o(unit_match_o), .range_output_o(range_output_o),
    .chain_output_o(chain_output_o));
  wcu_jtag_host host (.clk_i(clk_i), .tdo_i(tdo_o), .tck_o(tck_i), .tdi_o(tdi_i),
    .shift_dr_o(shift_dr_i), .update_dr_o(update_dr_i));

  // Linear feedback shift register step for repeatable stimulus.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction

  // Select code of register r in unit u.
  function automatic logic [4:0] sel(int u, int r);
    return {(u != 0 ? 2'h2 : wcu_pkg::SEL_UNIT0), r[2:0]};
  endfunction

  // Unmasked hit of a unit; a 16-bit fetch looks only at its valid lane.
  function automatic logic hit(int u, wcu_pkg::wcu_bus_s b, logic ext, logic rng);
    logic [31:0] lane;
    logic [7:0] ci;
    lane = 32'hffffffff;
    if (!b.acc && b.size == wcu_pkg::SIZE_HALF) begin
      lane = b.addr[1] ? wcu_pkg::LANE_HIGH : wcu_pkg::LANE_LOW;
    end
    ci = {rng, 1'b0, ext, b.priv, b.acc, b.size, b.write};
    return b.valid && (((b.addr ^ av[u]) & ~am[u]) == 32'h0) &&
      (((b.data ^ dv[u]) & ~dm[u] & lane) == 32'h0) && (((ci ^ cv[u][7:0]) & ~cm[u]) == 8'h0);
  endfunction

  // Checks the outputs of the last bus cycle, then drives the next one. With pat set
  // the cycle is a fetch that carries the unit 1 pattern in one data half only.
  task automatic step(input logic pat);
    logic [31:0] t;
    logic [15:0] p;
    logic h0, h1;
    wcu_pkg::wcu_bus_s b;
    @(negedge clk_i);
    `CHK(unit_match_o, um)
    `CHK(internal_break_signal_o, ib)
    `CHK(range_output_o, rg)
    `CHK(chain_output_o, ch)
    t = rnd();
    b.valid = t[0] | t[1];
    b.addr = av[1] ^ (rnd() & am[1]) ^ ((t[2:0] == 3'h0) ? 32'h10 : 32'h0);
    b.data = dv[1] ^ (rnd() & dm[1]) ^ ((t[5:3] == 3'h0) ? (32'h1 << t[10:6]) : 32'h0);
    {b.priv, b.acc, b.size, b.write} = cv[1][4:0] ^ (t[15:11] & t[20:16]);
    if (pat) begin
      // The other half is random, so word fetches should mostly miss.
      p = dv[1][15:0] ^ ((t[5:3] == 3'h0) ? 16'h1 : 16'h0);
      b.data = rnd();
      b.acc = 1'b0;
      b.size = t[9] ? wcu_pkg::SIZE_WORD : wcu_pkg::SIZE_HALF;
      if (b.addr[1]) begin
        b.data[31:16] = p;
      end else begin
        b.data[15:0] = p;
      end
    end
    bus_i = b;
    external_condition_i = {cv[1][5], cv[0][5]} ^ (t[23] ? t[25:24] : 2'h0);
    comparator_disable_i = (t[28:26] == 3'h0);
    h1 = hit(1, b, external_condition_i[1], 1'b0);
    h0 = hit(0, b, external_condition_i[0], h1);
    // With the data forced equal, hit tells whether address and control agree.
    b.data = dv[1];
    if (hit(1, b, external_condition_i[1], 1'b0)) begin
      ch = h1;
    end
    um = {h1 & cv[1][8], h0 & cv[0][8]} & {2{~comparator_disable_i}};
    ib = |um;
    rg = h1 & ~comparator_disable_i;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A run that stalls is cut short and counted as a failure.
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    logic [31:0] d, q, t;
    logic [37:0] g;
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    debug_test_reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    // Every register of both units reads back what was written, cut to its width.
    for (int u = 0; u < 2; u++) begin
      for (int r = 0; r < 6; r++) begin
        d = rnd();
        host.wr(sel(u, r), d);
        host.rd(sel(u, r), rnd(), q);
        `CHK(q, (r == 4) ? (d & 32'h1ff) : (r == 5) ? (d & 32'hff) : d)
      end
    end
    host.rd(5'h1f, rnd(), q);
    `CHK(q, 32'h0)
    // Both units get the same address and data pairs; unit 0 also needs the unit 1 range hit.
    t = rnd();
    av[1] = rnd();
    am[1] = 32'h3;
    dv[1] = rnd();
    dm[1] = rnd() & rnd();
    cv[1] = {t[8], 1'b0, t[6:0]};
    cm[1] = 8'hc0 | (t[15:8] & t[23:16] & 8'h3f);
    av[0] = av[1];
    am[0] = am[1];
    dv[0] = dv[1];
    dm[0] = dm[1];
    cv[0] = {2'h3, t[6:0]};
    cm[0] = 8'h40 | (cm[1] & 8'h3f);
    for (int u = 0; u < 2; u++) begin
      host.wr(sel(u, 0), av[u]);
      host.wr(sel(u, 1), am[u]);
      host.wr(sel(u, 2), dv[u]);
      host.wr(sel(u, 3), dm[u]);
      host.wr(sel(u, 4), {23'h0, cv[u]});
      host.wr(sel(u, 5), {24'h0, cm[u]});
    end
    comparator_disable_i = 1'b0;
    // Random bus cycles near the programmed values, each checked a cycle later.
    for (int n = 0; n < 600; n++) begin
      step(1'b0);
    end
    @(negedge clk_i);
    `CHK(chain_output_o, ch)
    bus_i.valid = 1'b0;
    // Software pattern breakpoint on unit 1: address ignored, pattern in both halves.
    comparator_disable_i = 1'b1;
    t = rnd();
    am[1] = 32'hffffffff;
    dv[1] = {t[15:0], t[15:0]};
    dm[1] = 32'h0;
    cv[1] = 9'h100;
    cm[1] = 8'hf7;
    host.wr(sel(1, 1), am[1]);
    host.wr(sel(1, 2), dv[1]);
    host.wr(sel(1, 3), dm[1]);
    host.wr(sel(1, 4), {23'h0, cv[1]});
    host.wr(sel(1, 5), {24'h0, cm[1]});
    comparator_disable_i = 1'b0;
    // The control value write has cleared the unit 1 chain register.
    um = 2'h0;
    ib = 1'b0;
    rg = 1'b0;
    ch = 1'b0;
    for (int n = 0; n < 200; n++) begin
      step(1'b1);
    end
    @(negedge clk_i);
    `CHK(chain_output_o, ch)
    bus_i.valid = 1'b0;
    // A debug test reset between read and shift-out clears the loaded data.
    host.scan({1'b0, sel(1, 2), rnd()}, g);
    debug_test_reset_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    debug_test_reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK(chain_output_o, 1'b0)
    host.scan(38'h0, g);
    `CHK(g[31:0], 32'h0)
    end_of_test();
  end
endmodule
